// ===== logic/rxf_filter.sv
// module: receive address filter, header checker and its wishbone register file
`timescale 1ns/1ps
module rxf_filter #(
    parameter int EXT_BYTES = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [4:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire rxf_pkg::rxf_hdr_t hdr_i,
    output rxf_pkg::rxf_result_t result_o,
    output logic accept_o,
    output logic [15:0] src_net_id_o,
    output logic irq_o
);
    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [3:0] reject_q, reject_d;
    logic [6:0] mode_q, mode_d;
    logic [15:0] short_q, short_d;
    logic [15:0] net_q, net_d;
    logic [63:0] ext_q, ext_d;
    logic [2:0] status_q, status_d;
    logic [2:0] mask_q, mask_d;
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    rxf_pkg::rxf_result_t res_q, res_d;
    logic accept_q, accept_d;
    logic [15:0] srcid_q, srcid_d;
    logic irq_q, irq_d;

    // byte-lane merge, used for every writable word
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    // low-byte mask of the extended id, as wide as the configured size
    function automatic logic [63:0] size_mask(input logic [2:0] nbytes);
        logic [63:0] m;
        m = '0;
        for (int i = 0; i < EXT_BYTES; i++) begin
            if (i < int'(nbytes)) begin
                m[8*i +: 8] = 8'hff;
            end
        end
        return m;
    endfunction : size_mask

    // ----------------------------------------------------------------
    // header decode
    // ----------------------------------------------------------------
    logic prop_mode, cks_rej, is_beacon, is_dc;
    logic cmp_eff, fmt_err, pid_ok, addr_me, bc_std, uni_std;
    logic nstd, pmatch, bc_prop, rej_std, rej_prop, reject;
    logic [63:0] pmask;

    always_comb begin
        prop_mode = mode_q[rxf_pkg::MODE_PROP];
        cks_rej = mode_q[rxf_pkg::MODE_CKS];
        is_beacon = hdr_i.ftype == rxf_pkg::FT_BEACON;
        is_dc = hdr_i.ftype == rxf_pkg::FT_DATA || hdr_i.ftype == rxf_pkg::FT_CMD;
        // compression only makes sense when both pid fields would exist
        cmp_eff = hdr_i.network_id_compress && hdr_i.dest_mode[1] && hdr_i.src_mode[1];
        fmt_err = !hdr_i.prop_frame && (hdr_i.dest_mode == rxf_pkg::AM_RSVD
                  || hdr_i.src_mode == rxf_pkg::AM_RSVD);
        pid_ok = hdr_i.dest_pid == net_q || hdr_i.dest_pid == rxf_pkg::ID_BCAST;
        addr_me = (hdr_i.dest_mode == rxf_pkg::AM_LONG) ? hdr_i.dest_addr == ext_q
                  : hdr_i.dest_addr[15:0] == short_q;
        bc_std = hdr_i.dest_mode == rxf_pkg::AM_SHORT && is_dc
                 && hdr_i.dest_addr[15:0] == rxf_pkg::ID_BCAST;
        uni_std = hdr_i.dest_mode[1] && !bc_std;
        nstd = hdr_i.dest_mode == rxf_pkg::AM_RSVD || hdr_i.src_mode == rxf_pkg::AM_RSVD
               || hdr_i.ftype[2] || hdr_i.fver[1];
        pmask = size_mask(mode_q[rxf_pkg::MODE_SIZE_LSB +: 3]);
        pmatch = (hdr_i.dest_addr & pmask) == (ext_q & pmask);
        bc_prop = hdr_i.bcast_flag && (is_dc || hdr_i.ftype == rxf_pkg::FT_STREAM);
        rej_std = (reject_q[rxf_pkg::REJ_TOME] && uni_std && pid_ok && addr_me)
                  || (reject_q[rxf_pkg::REJ_OTHER] && uni_std && !(pid_ok && addr_me))
                  || (reject_q[rxf_pkg::REJ_BC] && bc_std)
                  || (reject_q[rxf_pkg::REJ_NSTD] && nstd);
        // other-node check in proprietary framing moved to the checksum reject control
        rej_prop = (hdr_i.dest_present_flag && reject_q[rxf_pkg::REJ_TOME] && pmatch)
                   || (hdr_i.dest_present_flag && cks_rej && !pmatch)
                   || (reject_q[rxf_pkg::REJ_BC] && bc_prop);
        // mode/type combinations are deliberately not cross-checked
        reject = !is_beacon && ((hdr_i.prop_frame && prop_mode) ? rej_prop : rej_std);
    end

    // ----------------------------------------------------------------
    // result, status and interrupt
    // ----------------------------------------------------------------
    logic st_rd;
    always_comb begin
        res_d = '0;
        accept_d = 1'b0;
        srcid_d = srcid_q;
        if (hdr_i.valid) begin
            res_d.format_error_flag = fmt_err;
            res_d.rx_filtered_flag = !fmt_err && reject;
            res_d.rx_done_flag = !fmt_err && !reject;
            accept_d = !fmt_err && !reject;
            srcid_d = cmp_eff ? hdr_i.dest_pid : hdr_i.src_pid;
        end
        st_rd = ack_d && !wb_we_i && wb_adr_i == rxf_pkg::ADR_STATUS;
        // read clears, but an event in the same cycle survives the clear
        status_d = (st_rd ? 3'h0 : status_q)
                   | {res_d.format_error_flag, res_d.rx_filtered_flag, res_d.rx_done_flag};
        irq_d = |(status_d & mask_q);
    end

    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    logic [31:0] wr;
    always_comb begin
        reject_d = reject_q;
        mode_d = mode_q;
        short_d = short_q;
        net_d = net_q;
        ext_d = ext_q;
        mask_d = mask_q;
        rdat_d = 32'h0;
        wr = 32'h0;
        // single-cycle answer; ack drops the cycle after it is given
        ack_d = wb_cyc_i && wb_stb_i && !ack_q;
        case (wb_adr_i)
            rxf_pkg::ADR_REJECT: wr = {28'h0, reject_q};
            rxf_pkg::ADR_MODE: wr = {25'h0, mode_q};
            rxf_pkg::ADR_SHORT: wr = {16'h0, short_q};
            rxf_pkg::ADR_NET: wr = {16'h0, net_q};
            rxf_pkg::ADR_EXT_LO: wr = ext_q[31:0];
            rxf_pkg::ADR_EXT_HI: wr = ext_q[63:32];
            rxf_pkg::ADR_STATUS: wr = {29'h0, status_q};
            rxf_pkg::ADR_MASK: wr = {29'h0, mask_q};
            default: wr = 32'h0;
        endcase
        if (ack_d && !wb_we_i) begin
            rdat_d = wr;
        end
        wr = lane_merge(wr, wb_dat_i, wb_sel_i);
        // a write lands on the edge where the master sees ack, not one earlier
        if (ack_q && wb_cyc_i && wb_stb_i && wb_we_i) begin
            case (wb_adr_i)
                rxf_pkg::ADR_REJECT: reject_d = wr[3:0];
                rxf_pkg::ADR_MODE: mode_d = {wr[6:4], 2'h0, wr[1:0]};
                rxf_pkg::ADR_SHORT: short_d = wr[15:0];
                rxf_pkg::ADR_NET: net_d = wr[15:0];
                rxf_pkg::ADR_EXT_LO: ext_d[31:0] = wr;
                rxf_pkg::ADR_EXT_HI: ext_d[63:32] = wr;
                rxf_pkg::ADR_MASK: mask_d = wr[2:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reject_q <= rxf_pkg::REJECT_RST;
            mode_q <= rxf_pkg::MODE_RST;
            short_q <= rxf_pkg::SHORT_RST;
            net_q <= rxf_pkg::NET_RST;
            ext_q <= rxf_pkg::EXT_RST;
            mask_q <= rxf_pkg::MASK_RST;
            status_q <= 3'h0;
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            res_q <= '0;
            accept_q <= 1'b0;
            srcid_q <= 16'h0;
            irq_q <= 1'b0;
        end else begin
            reject_q <= reject_d;
            mode_q <= mode_d;
            short_q <= short_d;
            net_q <= net_d;
            ext_q <= ext_d;
            mask_q <= mask_d;
            status_q <= status_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            res_q <= res_d;
            accept_q <= accept_d;
            srcid_q <= srcid_d;
            irq_q <= irq_d;
        end
    end

    assign wb_dat_o = rdat_q;
    assign wb_ack_o = ack_q;
    assign result_o = res_q;
    assign accept_o = accept_q;
    assign src_net_id_o = srcid_q;
    assign irq_o = irq_q;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    a_beacon_never_filtered: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.ftype == rxf_pkg::FT_BEACON |=> !result_o.rx_filtered_flag)
        else $error("beacon frame was filtered");
    a_reserved_mode_fmt: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && (hdr_i.dest_mode == 2'h1 || hdr_i.src_mode == 2'h1)
        |=> result_o.format_error_flag && !accept_o)
        else $error("reserved addressing mode not flagged");
    a_one_outcome: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(hdr_i.valid) |-> $onehot({result_o.rx_done_flag, result_o.rx_filtered_flag,
                                          result_o.format_error_flag}))
        else $error("frame ended without exactly one outcome");
    a_no_reject_done: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && reject_q == 4'h0 && !mode_q[1] && hdr_i.dest_mode != 2'h1
        && hdr_i.src_mode != 2'h1 |=> result_o.rx_done_flag && accept_o)
        else $error("frame lost with all reject bits clear");
    a_tome_rejected: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q[3] && hdr_i.dest_mode == 2'h3
        && hdr_i.dest_pid == net_q && hdr_i.dest_addr == ext_q && hdr_i.src_mode != 2'h1
        && hdr_i.ftype != 3'h0 |=> result_o.rx_filtered_flag)
        else $error("unicast to this node not rejected");
    a_implied_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q == 4'hc && hdr_i.dest_mode == 2'h0
        && hdr_i.src_mode != 2'h1 |=> result_o.rx_done_flag)
        else $error("implied addressing filtered by unicast reject");
    a_bcast_std_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q[1] && hdr_i.dest_mode == 2'h2
        && hdr_i.dest_addr[15:0] == 16'hffff && hdr_i.ftype == 3'h1 && hdr_i.src_mode != 2'h1
        |=> result_o.rx_filtered_flag)
        else $error("broadcast data frame not rejected");
    a_src_pid_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.network_id_compress && hdr_i.dest_mode[1] && hdr_i.src_mode[1]
        |=> src_net_id_o == $past(hdr_i.dest_pid))
        else $error("compressed source pid not taken from dest pid");
    // skip the edge after a reset: its past values predate the reset
    a_irq_follows: assert property (@(posedge clk_i) disable iff (rst_i)
        !$past(rst_i) |-> irq_o == |($past(status_d) & $past(mask_q)))
        else $error("interrupt does not follow masked status");

    a_status_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
        result_o.rx_done_flag |-> status_q[0] ##1 (status_q[0] || $past(st_rd)))
        else $error("done status bit lost without a read");

    // standard path, and pid compression in either framing
    a_other_node_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q[2] && hdr_i.dest_mode == 2'h2
        && hdr_i.dest_pid != net_q && hdr_i.dest_pid != 16'hffff && hdr_i.ftype != 3'h0
        && hdr_i.dest_addr[15:0] != 16'hffff && hdr_i.src_mode != 2'h1
        |=> result_o.rx_filtered_flag)
        else $error("unicast for another node kept");

    a_nonstd_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q[0] && hdr_i.ftype != 3'h0
        && (hdr_i.ftype[2] || hdr_i.fver[1]) && hdr_i.dest_mode != 2'h1
        && hdr_i.src_mode != 2'h1 |=> result_o.rx_filtered_flag)
        else $error("non-standard frame kept");

    a_bcast_pid_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q[2] && !reject_q[3] && !reject_q[0]
        && hdr_i.dest_mode == 2'h3 && hdr_i.dest_pid == 16'hffff && hdr_i.dest_addr == ext_q
        && hdr_i.src_mode != 2'h1 |=> result_o.rx_done_flag)
        else $error("long frame with ffff pid dropped");

    a_bad_compress: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.network_id_compress && !(hdr_i.dest_mode[1] && hdr_i.src_mode[1])
        |=> src_net_id_o == $past(hdr_i.src_pid))
        else $error("inconsistent compression honoured");

    a_short_me_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && !hdr_i.prop_frame && reject_q[3] && hdr_i.dest_mode == 2'h2
        && hdr_i.dest_pid == net_q && hdr_i.dest_addr[15:0] == short_q
        && hdr_i.dest_addr[15:0] != 16'hffff && hdr_i.ftype != 3'h0 && hdr_i.src_mode != 2'h1
        |=> result_o.rx_filtered_flag)
        else $error("short unicast to this node kept");

    // proprietary path
    a_bcast_prop_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.prop_frame && mode_q[0] && reject_q[1] && hdr_i.bcast_flag
        && hdr_i.ftype == 3'h4 |=> result_o.rx_filtered_flag)
        else $error("proprietary broadcast kept");

    a_prop_match_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.prop_frame && mode_q[0] && reject_q[3] && hdr_i.dest_present_flag
        && mode_q[6:4] == 3'h2 && hdr_i.dest_addr[15:0] == ext_q[15:0] && hdr_i.ftype != 3'h0
        |=> result_o.rx_filtered_flag)
        else $error("proprietary frame for this node kept");

    a_cks_other_rej: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.prop_frame && mode_q[1:0] == 2'h3 && hdr_i.dest_present_flag
        && mode_q[6:4] == 3'h2 && hdr_i.dest_addr[15:0] != ext_q[15:0] && hdr_i.ftype != 3'h0
        |=> result_o.rx_filtered_flag)
        else $error("proprietary frame for another node kept");

    a_prop_bits_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.prop_frame && mode_q[1:0] == 2'h1
        && (reject_q == 4'h4 || reject_q == 4'h1) |=> result_o.rx_done_flag)
        else $error("proprietary frame dropped by a standard bit");

    a_inferred_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        hdr_i.valid && hdr_i.prop_frame && mode_q[0] && !hdr_i.dest_present_flag
        && !hdr_i.bcast_flag |=> result_o.rx_done_flag)
        else $error("inferred addressing filtered");

    // bus and result
    a_rdat_idle: assert property (@(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside an acknowledge");

    a_accept_done: assert property (@(posedge clk_i) disable iff (rst_i)
        accept_o == result_o.rx_done_flag)
        else $error("accept differs from done flag");

    a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
endmodule : rxf_filter

// ===== logic/rxf_pkg.sv
// package: register map, field layout, codes and carriers of the receive address filter
package rxf_pkg;
    // ----------------------------------------------------------------
    // register byte offsets
    // ----------------------------------------------------------------
    localparam logic [4:0] ADR_REJECT = 5'h00;
    localparam logic [4:0] ADR_MODE = 5'h04;
    localparam logic [4:0] ADR_SHORT = 5'h08;
    localparam logic [4:0] ADR_NET = 5'h0c;
    localparam logic [4:0] ADR_EXT_LO = 5'h10;
    localparam logic [4:0] ADR_EXT_HI = 5'h14;
    localparam logic [4:0] ADR_STATUS = 5'h18;
    localparam logic [4:0] ADR_MASK = 5'h1c;
    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int REJ_NSTD = 0;
    localparam int REJ_BC = 1;
    localparam int REJ_OTHER = 2;
    localparam int REJ_TOME = 3;
    localparam int MODE_PROP = 0;
    localparam int MODE_CKS = 1;
    localparam int MODE_SIZE_LSB = 4;
    localparam int ST_DONE = 0;
    localparam int ST_FILT = 1;
    localparam int ST_FMT = 2;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [3:0] REJECT_RST = 4'h0;
    localparam logic [6:0] MODE_RST = 7'h20;
    localparam logic [15:0] SHORT_RST = 16'hffff;
    localparam logic [15:0] NET_RST = 16'hffff;
    localparam logic [63:0] EXT_RST = 64'h0;
    localparam logic [2:0] MASK_RST = 3'h0;
    // ----------------------------------------------------------------
    // header codes
    // ----------------------------------------------------------------
    localparam logic [15:0] ID_BCAST = 16'hffff;
    localparam logic [1:0] AM_NONE = 2'h0;
    localparam logic [1:0] AM_RSVD = 2'h1;
    localparam logic [1:0] AM_SHORT = 2'h2;
    localparam logic [1:0] AM_LONG = 2'h3;
    localparam logic [2:0] FT_BEACON = 3'h0;
    localparam logic [2:0] FT_DATA = 3'h1;
    localparam logic [2:0] FT_CMD = 3'h3;
    localparam logic [2:0] FT_STREAM = 3'h4;
    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic valid;
        logic prop_frame;
        logic [2:0] ftype;
        logic [1:0] fver;
        logic [1:0] dest_mode;
        logic [1:0] src_mode;
        logic network_id_compress;
        logic bcast_flag;
        logic dest_present_flag;
        logic [15:0] dest_pid;
        logic [63:0] dest_addr;
        logic [15:0] src_pid;
    } rxf_hdr_t;
    typedef struct packed {
        logic rx_done_flag;
        logic rx_filtered_flag;
        logic format_error_flag;
    } rxf_result_t;
endpackage : rxf_pkg

// ===== verification/rxf_frame_src.sv
// far-side model: a remote transmitter handing parsed frame headers to the filter
`timescale 1ns/1ps
module rxf_frame_src (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire rxf_pkg::rxf_hdr_t frame_i,
    output rxf_pkg::rxf_hdr_t hdr_o
);
    // ----------------------------------------------------------------
    // header launch
    // ----------------------------------------------------------------
    rxf_pkg::rxf_hdr_t hdr_d;
    always_comb begin
        // fields are not held between frames, so a filter that samples late sees garbage
        hdr_d = ~hdr_o;
        hdr_d.valid = 1'b0;
        if (send_i) begin
            hdr_d = frame_i;
            hdr_d.valid = 1'b1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hdr_o <= '0;
        end else begin
            hdr_o <= hdr_d;
        end
    end
endmodule : rxf_frame_src

// ===== verification/testbench.sv
// testbench: registers, filter outcomes and interrupt of the receive address filter
`timescale 1ns/1ps
module testbench;
    // ----------------------------------------------------------------
    // signals and constants
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] rej;
        logic [6:0] mode;
        rxf_pkg::rxf_hdr_t h;
        logic [2:0] exp;
    } rxf_row_t;
    localparam logic [15:0] NET = 16'habcd;
    localparam logic [63:0] SHA = 64'h1234;
    localparam logic [63:0] EXT = 64'h0102030405060708;
    localparam logic [6:0] MS = 7'h20;
    localparam logic [6:0] MP = 7'h21;
    localparam logic [6:0] MC = 7'h23;
    localparam logic [2:0] OK = 3'h4;
    localparam logic [2:0] FI = 3'h2;
    localparam logic [2:0] FE = 3'h1;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [4:0] wb_adr = 5'h0;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_wdat = 32'h0;
    logic [31:0] wb_rdat;
    logic wb_ack;
    logic fsend = 1'b0;
    rxf_pkg::rxf_hdr_t ffrm = '0;
    rxf_pkg::rxf_hdr_t hdr;
    rxf_pkg::rxf_result_t result;
    logic accept;
    logic [15:0] src_id;
    logic irq;
    int fail_count = 0;
    int num_checks = 0;
    int cycles = 0;
    rxf_row_t rows[$];
    always #2.5 clk_i = ~clk_i;
    rxf_filter #(.EXT_BYTES(8)) u_rxf_filter (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc),
        .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
        .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .hdr_i(hdr),
        .result_o(result), .accept_o(accept), .src_net_id_o(src_id), .irq_o(irq));
    rxf_frame_src u_rxf_frame_src (.clk_i(clk_i), .rst_i(rst_i), .send_i(fsend),
        .frame_i(ffrm), .hdr_o(hdr));
    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test
    task automatic wb(input logic [4:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge clk_i);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_sel <= 4'hf;
        wb_wdat <= d;
        do begin
            @(posedge clk_i);
        end while (wb_ack !== 1'b1);
        q = wb_rdat;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb
    task automatic send(input rxf_pkg::rxf_hdr_t h);
        @(posedge clk_i);
        fsend <= 1'b1;
        ffrm <= h;
        @(posedge clk_i);
        fsend <= 1'b0;
        @(posedge clk_i);
        #1;
    endtask : send
    function automatic rxf_pkg::rxf_hdr_t hd(input logic p, input logic [2:0] ft,
        input logic [1:0] fv, dm, sm, input logic c, b, dp, input logic [15:0] dpid,
        input logic [63:0] da, input logic [15:0] sp);
        hd = {1'b1, p, ft, fv, dm, sm, c, b, dp, dpid, da, sp};
    endfunction : hd
    task automatic add(input logic [3:0] r, input logic [6:0] m, input rxf_pkg::rxf_hdr_t h,
                       input logic [2:0] e);
        rows.push_back({r, m, h, e});
    endtask : add
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            end_of_test();
        end
    end
    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [31:0] rd;
        logic [15:0] es;
        logic [4:0] ra[8];
        logic [31:0] rv[8];
        ra = '{5'h00, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h1c, 5'h02};
        rv = '{32'h0, 32'h20, 32'hffff, 32'hffff, 32'h0, 32'h0, 32'h0, 32'h0};
        add(4'h0, MS, hd(0, 1, 0, 2, 2, 0, 0, 0, NET, SHA, 16'h1111), OK);
        add(4'h8, MS, hd(0, 1, 0, 2, 2, 0, 0, 0, NET, SHA, 16'h1111), FI);
        add(4'h8, MS, hd(0, 3, 0, 2, 0, 0, 0, 0, 16'hffff, SHA, 0), FI);
        add(4'h8, MS, hd(0, 1, 0, 3, 2, 0, 0, 0, NET, EXT, 0), FI);
        add(4'h4, MS, hd(0, 1, 0, 3, 2, 0, 0, 0, NET, EXT, 0), OK);
        add(4'h4, MS, hd(0, 1, 0, 2, 2, 0, 0, 0, NET, 64'h5555, 0), FI);
        add(4'h4, MS, hd(0, 1, 0, 2, 2, 0, 0, 0, 16'h1111, SHA, 0), FI);
        add(4'h2, MS, hd(0, 1, 0, 2, 2, 0, 0, 0, NET, 64'hffff, 0), FI);
        add(4'h2, MS, hd(0, 3, 0, 2, 0, 0, 0, 0, NET, 64'hffff, 0), FI);
        add(4'h6, MS, hd(0, 1, 0, 3, 3, 0, 0, 0, 16'hffff, EXT, 16'hffff), OK);
        add(4'h1, MS, hd(0, 1, 2, 2, 2, 0, 0, 0, NET, SHA, 0), FI);
        add(4'h1, MS, hd(0, 4, 0, 2, 2, 0, 0, 0, NET, SHA, 0), FI);
        add(4'h1, MS, hd(0, 1, 0, 2, 1, 0, 0, 0, NET, SHA, 0), FE);
        add(4'h0, MS, hd(0, 1, 0, 1, 2, 0, 0, 0, NET, SHA, 0), FE);
        add(4'hf, MS, hd(0, 0, 0, 0, 2, 0, 0, 0, 0, 0, NET), OK);
        add(4'hc, MS, hd(0, 1, 0, 0, 2, 0, 0, 0, 0, 0, 16'h2222), OK);
        add(4'h2, MP, hd(1, 4, 0, 0, 0, 0, 1, 0, 0, 0, 0), FI);
        add(4'h2, MP, hd(1, 3, 0, 0, 0, 0, 1, 0, 0, 0, 0), FI);
        add(4'h4, MP, hd(1, 1, 0, 0, 0, 0, 0, 1, 0, 64'h5555, 0), OK);
        add(4'h0, MC, hd(1, 1, 0, 0, 0, 0, 0, 1, 0, 64'h5555, 0), FI);
        add(4'h8, MP, hd(1, 1, 0, 0, 0, 0, 0, 1, 0, 64'hff0708, 0), FI);
        add(4'h8, MP, hd(1, 1, 0, 0, 0, 0, 0, 0, 0, 64'h0708, 0), OK);
        add(4'h8, 7'h41, hd(1, 1, 0, 0, 0, 0, 0, 1, 0, 64'h05000708, 0), OK);
        add(4'h1, MP, hd(1, 4, 2, 0, 0, 0, 0, 0, 0, 0, 0), OK);
        add(4'h0, MS, hd(0, 1, 0, 2, 2, 1, 0, 0, NET, SHA, 16'h3333), OK);
        add(4'h0, MS, hd(0, 1, 0, 0, 2, 1, 0, 0, NET, 0, 16'h3333), OK);
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            wb(ra[i], 1'b0, 32'h0, rd);
            check(rd, rv[i]);
        end
        $display("test reset values done");
        wb(rxf_pkg::ADR_SHORT, 1'b1, 32'h1234, rd);
        wb(rxf_pkg::ADR_NET, 1'b1, {16'h0, NET}, rd);
        wb(rxf_pkg::ADR_EXT_LO, 1'b1, EXT[31:0], rd);
        wb(rxf_pkg::ADR_EXT_HI, 1'b1, EXT[63:32], rd);
        wb(rxf_pkg::ADR_EXT_HI, 1'b0, 32'h0, rd);
        check(rd, EXT[63:32]);
        foreach (rows[i]) begin
            wb(rxf_pkg::ADR_REJECT, 1'b1, {28'h0, rows[i].rej}, rd);
            wb(rxf_pkg::ADR_MODE, 1'b1, {25'h0, rows[i].mode}, rd);
            send(rows[i].h);
            es = rows[i].h.network_id_compress && rows[i].h.dest_mode[1] &&
                rows[i].h.src_mode[1] ? rows[i].h.dest_pid : rows[i].h.src_pid;
            check({29'h0, result}, {29'h0, rows[i].exp});
            check({31'h0, accept}, {31'h0, rows[i].exp[2]});
            if (rows[i].exp != FE) check({16'h0, src_id}, {16'h0, es});
        end
        $display("test filter table done");
        wb(rxf_pkg::ADR_STATUS, 1'b0, 32'h0, rd);
        wb(rxf_pkg::ADR_MASK, 1'b1, 32'h2, rd);
        wb(rxf_pkg::ADR_REJECT, 1'b1, 32'h8, rd);
        wb(rxf_pkg::ADR_MODE, 1'b1, {25'h0, MS}, rd);
        send(rows[1].h);
        @(posedge clk_i);
        #1;
        check({31'h0, irq}, 32'h1);
        wb(rxf_pkg::ADR_STATUS, 1'b0, 32'h0, rd);
        check(rd, 32'h2);
        repeat (2) @(posedge clk_i);
        #1;
        check({31'h0, irq}, 32'h0);
        send(rows[5].h);
        @(posedge clk_i);
        #1;
        check({31'h0, irq}, 32'h0);
        wb(rxf_pkg::ADR_STATUS, 1'b0, 32'h0, rd);
        check(rd, 32'h1);
        $display("test interrupt done");
        // two frames on consecutive cycles, each must give its own flag
        @(posedge clk_i);
        fsend <= 1'b1;
        ffrm <= rows[1].h;
        @(posedge clk_i);
        ffrm <= rows[5].h;
        @(posedge clk_i);
        fsend <= 1'b0;
        #1;
        check({29'h0, result}, {29'h0, FI});
        @(posedge clk_i);
        #1;
        check({29'h0, result}, {29'h0, OK});
        $display("test back to back done");
        wb(rxf_pkg::ADR_REJECT, 1'b1, 32'hf, rd);
        @(posedge clk_i);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(rxf_pkg::ADR_REJECT, 1'b0, 32'h0, rd);
        check(rd, 32'h0);
        check({31'h0, irq}, 32'h0);
        check({29'h0, result}, 32'h0);
        $display("test second reset done");
        end_of_test();
    end
endmodule : testbench
